// ---- shared/wwd_pkg.sv ----
// How it works
// - After every reset the watchdog comes up enabled and counting with no software action.
// - The disable and enable commands stop or restart the watchdog in the cycle after they arrive.
// - A counter overflow before a service raises the reset request.
// - A service while the watchdog is enabled and the count is still below the window boundary also raises the reset request.
// - The counter is 16 bits wide and counts up by one on each prescaled tick.
// - The count source is the system clock or the wake-up oscillator, divided by 16384 or 256.
// - Each service loads the counter from the reload value register.
// - Out of reset the timeout is 0.13 s on the 500 kHz wake-up clock.
`default_nettype none
package wwd_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W  = 16;
  localparam int PRE_W  = 14;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_RELOAD = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_WINDOW = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_COUNT  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_CMD    = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_MASK   = 8'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_CLKSEL = 0;
  localparam int CTRL_DIVSEL = 1;
  localparam int CMD_SERVICE = 0;
  localparam int CMD_DISABLE = 1;
  localparam int CMD_ENABLE  = 2;
  localparam int ST_OVF      = 0;
  localparam int ST_EARLY    = 1;
  localparam int ST_EN       = 2;
  localparam int ST_REQ      = 3;

  // ----------------------------------------------------------------
  // Prescaler limits
  // ----------------------------------------------------------------
  localparam int DIV_HI = 16384;
  localparam int DIV_LO = 256;
  localparam logic [PRE_W-1:0] DIV_HI_MAX = PRE_W'(DIV_HI - 1);
  localparam logic [PRE_W-1:0] DIV_LO_MAX = PRE_W'(DIV_LO - 1);

  // ----------------------------------------------------------------
  // Default timeout on the wake-up clock
  // ----------------------------------------------------------------
  localparam int WAKE_FREQ_KHZ  = 500;
  localparam int DEF_TIMEOUT_US = 130000;
  localparam int DEF_TICKS =
    (DEF_TIMEOUT_US * WAKE_FREQ_KHZ / 1000 + DIV_LO - 1) / DIV_LO;

  // ----------------------------------------------------------------
  // Reset values and answers
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] CNT_MAX    = 16'hFFFF;
  localparam logic [CNT_W-1:0] RELOAD_RST = CNT_W'(65536 - DEF_TICKS);
  localparam logic [CNT_W-1:0] WIN_RST    = 16'h0000;
  localparam logic [1:0]       CTRL_RST   = 2'h3;
  localparam logic [1:0]       MASK_RST   = 2'h0;
  localparam logic [1:0]       RESP_OKAY  = 2'h0;
  localparam logic [1:0]       RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ---- logic/wwd_prescaler.sv ----
`timescale 1ns/10ps
`default_nettype none
module wwd_prescaler
  import wwd_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rstN,
  // Control
  input  wire logic srcTick,
  input  wire logic clear,
  input  wire logic divSel,
  // Prescaled tick
  output logic      tick
);
  logic [PRE_W-1:0] cnt_q;
  logic [PRE_W-1:0] cnt_d;
  logic             tick_q;
  wire  [PRE_W-1:0] limit   = divSel ? DIV_LO_MAX : DIV_HI_MAX;
  wire              atLimit = cnt_q == limit;

  assign cnt_d = clear ? '0 : !srcTick ? cnt_q : atLimit ? '0 : cnt_q + 1'b1;
  assign tick  = tick_q;

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= srcTick && atLimit && !clear;
    end
  end

  chk_tick_gap: assert property (@(posedge ref_clk) disable iff (!rstN)
    tick_q |=> !tick_q [*8])
    else $error("prescaled ticks too close");
endmodule // wwd_prescaler
`default_nettype wire

// ---- logic/wwd_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module wwd_top
  import wwd_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              arst_n,
  // Wake-up oscillator clock, asynchronous
  input  wire logic              wakeClk,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // AXI4-Lite read data
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // To system reset logic and interrupt controller
  output logic                   wdResetReq,
  output logic                   irq
);
  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  logic rstS1_q;
  logic rstN;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstS1_q <= 1'b0;
      rstN    <= 1'b0;
    end else begin
      rstS1_q <= 1'b1;
      rstN    <= rstS1_q;
    end
  end

  // ----------------------------------------------------------------
  // Wake clock synchroniser and edge detect
  // ----------------------------------------------------------------
  logic wakeS1_q;
  logic wakeS2_q;
  logic wakeS3_q;
  wire  wakeRise = wakeS2_q && !wakeS3_q;

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      wakeS1_q <= 1'b0;
      wakeS2_q <= 1'b0;
      wakeS3_q <= 1'b0;
    end else begin
      wakeS1_q <= wakeClk;
      wakeS2_q <= wakeS1_q;
      wakeS3_q <= wakeS2_q;
    end
  end

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [1:0]       ctrl_q;
  logic [1:0]       ctrl_d;
  logic [CNT_W-1:0] reload_q;
  logic [CNT_W-1:0] reload_d;
  logic [CNT_W-1:0] win_q;
  logic [CNT_W-1:0] win_d;
  logic [1:0]       mask_q;
  logic [1:0]       mask_d;
  logic [1:0]       st_q;
  logic [1:0]       st_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             wdEn_q;
  logic             wdEn_d;
  logic             req_q;
  logic             req_d;
  logic             irq_q;
  logic             wrHit;

  // ----------------------------------------------------------------
  // AXI write channel
  // ----------------------------------------------------------------
  logic              awHeld_q;
  logic              awHeld_d;
  logic [ADDR_W-1:0] awAddr_q;
  logic              wHeld_q;
  logic              wHeld_d;
  logic [DATA_W-1:0] wData_q;
  logic [3:0]        wStrb_q;
  logic              bvalid_q;
  logic              bvalid_d;
  logic [1:0]        bresp_q;

  wire awTake = s_axi_awvalid && s_axi_awready;
  wire wTake  = s_axi_wvalid && s_axi_wready;
  wire wrGo   = awHeld_q && wHeld_q && !bvalid_q;

  assign s_axi_awready = !awHeld_q && !bvalid_q;
  assign s_axi_wready  = !wHeld_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  assign awHeld_d = wrGo ? 1'b0 : awTake ? 1'b1 : awHeld_q;
  assign wHeld_d  = wrGo ? 1'b0 : wTake ? 1'b1 : wHeld_q;
  assign bvalid_d = wrGo ? 1'b1 : (bvalid_q && s_axi_bready) ? 1'b0 : bvalid_q;

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
      awAddr_q <= '0;
      wData_q  <= '0;
      wStrb_q  <= '0;
    end else begin
      awHeld_q <= awHeld_d;
      wHeld_q  <= wHeld_d;
      bvalid_q <= bvalid_d;
      if (awTake) begin
        awAddr_q <= s_axi_awaddr;
      end
      if (wTake) begin
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (wrGo) begin
        bresp_q <= wrHit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  wire [DATA_W-1:0] wMask = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}},
                             {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
  wire [DATA_W-1:0] wBits = wData_q & wMask;
  wire wrCtrl   = wrGo && awAddr_q == OFF_CTRL;
  wire wrReload = wrGo && awAddr_q == OFF_RELOAD;
  wire wrWindow = wrGo && awAddr_q == OFF_WINDOW;
  wire wrCount  = wrGo && awAddr_q == OFF_COUNT;
  wire wrCmd    = wrGo && awAddr_q == OFF_CMD;
  wire wrStatus = wrGo && awAddr_q == OFF_STATUS;
  wire wrMaskR  = wrGo && awAddr_q == OFF_MASK;
  assign wrHit  = wrCtrl || wrReload || wrWindow || wrCount
               || wrCmd || wrStatus || wrMaskR;

  wire [CNT_W-1:0] reloadMrg = (reload_q & ~wMask[CNT_W-1:0]) | wBits[CNT_W-1:0];
  wire [CNT_W-1:0] winMrg    = (win_q & ~wMask[CNT_W-1:0]) | wBits[CNT_W-1:0];
  wire [1:0]       ctrlMrg   = (ctrl_q & ~wMask[1:0]) | wBits[1:0];
  wire [1:0]       maskMrg   = (mask_q & ~wMask[1:0]) | wBits[1:0];

  // ----------------------------------------------------------------
  // Commands from AXI writes to the command register
  // ----------------------------------------------------------------
  wire svc    = wrCmd && wBits[CMD_SERVICE];
  wire disCmd = wrCmd && wBits[CMD_DISABLE];
  wire enCmd  = wrCmd && wBits[CMD_ENABLE];

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  logic tick;
  wire  clkSel  = ctrl_q[CTRL_CLKSEL];
  wire  srcTick = wdEn_q && (clkSel ? wakeRise : 1'b1);

  wwd_prescaler u_pre (
    .ref_clk (ref_clk),
    .rstN    (rstN),
    .srcTick (srcTick),
    .clear   (svc),
    .divSel  (ctrl_q[CTRL_DIVSEL]),
    .tick    (tick)
  );

  // ----------------------------------------------------------------
  // Watchdog core
  // ----------------------------------------------------------------
  wire atMax = cnt_q == CNT_MAX;
  wire ovf   = wdEn_q && tick && atMax && !svc;
  wire early = svc && wdEn_q && cnt_q < win_q;

  assign wdEn_d   = enCmd ? 1'b1 : disCmd ? 1'b0 : wdEn_q;
  assign cnt_d    = svc ? reload_q
                  : (wdEn_q && tick) ? cnt_q + 16'h0001 : cnt_q;
  assign req_d    = req_q || ovf || early;
  assign ctrl_d   = wrCtrl ? ctrlMrg : ctrl_q;
  assign reload_d = wrReload ? reloadMrg : reload_q;
  assign win_d    = wrWindow ? winMrg : win_q;
  assign mask_d   = wrMaskR ? maskMrg : mask_q;

  // ----------------------------------------------------------------
  // Sticky status, set wins over clear
  // ----------------------------------------------------------------
  logic [1:0] stSet;
  wire  [1:0] stClr = wrStatus ? wBits[1:0] : 2'h0;

  assign stSet[ST_OVF]   = ovf;
  assign stSet[ST_EARLY] = early;
  assign st_d            = (st_q & ~stClr) | stSet;

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      wdEn_q   <= 1'b1;
      cnt_q    <= RELOAD_RST;
      reload_q <= RELOAD_RST;
      ctrl_q   <= CTRL_RST;
      win_q    <= WIN_RST;
      mask_q   <= MASK_RST;
      st_q     <= '0;
      req_q    <= 1'b0;
      irq_q    <= 1'b0;
    end else begin
      wdEn_q   <= wdEn_d;
      cnt_q    <= cnt_d;
      reload_q <= reload_d;
      ctrl_q   <= ctrl_d;
      win_q    <= win_d;
      mask_q   <= mask_d;
      st_q     <= st_d;
      req_q    <= req_d;
      irq_q    <= |(st_d & mask_d);
    end
  end

  assign wdResetReq = req_q;
  assign irq        = irq_q;

  // ----------------------------------------------------------------
  // AXI read channel
  // ----------------------------------------------------------------
  logic              rvalid_q;
  logic [DATA_W-1:0] rdata_q;
  logic [1:0]        rresp_q;

  wire rdGo = s_axi_arvalid && s_axi_arready;
  wire [ADDR_W-1:0] rAddr = s_axi_araddr;
  wire [3:0] stRead = {req_q, wdEn_q, st_q};
  wire rdHit = rAddr == OFF_CTRL || rAddr == OFF_RELOAD || rAddr == OFF_WINDOW
            || rAddr == OFF_COUNT || rAddr == OFF_CMD || rAddr == OFF_STATUS
            || rAddr == OFF_MASK;
  wire [DATA_W-1:0] rdMux =
      rAddr == OFF_CTRL   ? DATA_W'(ctrl_q)
    : rAddr == OFF_RELOAD ? DATA_W'(reload_q)
    : rAddr == OFF_WINDOW ? DATA_W'(win_q)
    : rAddr == OFF_COUNT  ? DATA_W'(cnt_q)
    : rAddr == OFF_STATUS ? DATA_W'(stRead)
    : rAddr == OFF_MASK   ? DATA_W'(mask_q)
    : '0;

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end else if (rdGo) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rdMux;
      rresp_q  <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstN);

  chk_rst_enabled: assert property ($rose(rstN) |-> wdEn_q && !req_q)
    else $error("watchdog not enabled after reset");

  chk_disable_now: assert property (disCmd && !enCmd |=> !wdEn_q)
    else $error("disable not honoured");

  chk_enable_now: assert property (enCmd |=> wdEn_q ##1 wdEn_q || disCmd)
    else $error("enable not honoured");

  chk_ovf_request: assert property (wdEn_q && tick && atMax && !svc |=> req_q)
    else $error("overflow gave no reset request");

  chk_early_request: assert property (svc && wdEn_q && cnt_q < win_q |=> req_q)
    else $error("early service gave no reset request");

  chk_late_service: assert property (!req_q && svc && cnt_q >= win_q |=> !req_q)
    else $error("legal service gave reset request");

  chk_count_up: assert property (wdEn_q && tick && !svc |=>
    cnt_q == $past(cnt_q) + 16'h0001)
    else $error("counter did not step by one");

  chk_count_hold: assert property (!tick && !svc |=> $stable(cnt_q))
    else $error("counter moved without tick");

  chk_reload_load: assert property (svc |=> cnt_q == $past(reload_q))
    else $error("service did not load reload value");

  chk_default_cfg: assert property ($rose(rstN) |->
    reload_q == RELOAD_RST && ctrl_q == CTRL_RST && cnt_q == RELOAD_RST)
    else $error("wrong default timeout setup");

  chk_req_sticky: assert property (req_q |=> req_q)
    else $error("reset request dropped");

  chk_stop_hold: assert property (!wdEn_q && !svc |=> $stable(cnt_q))
    else $error("counter moved while stopped");

  chk_reload_keep: assert property (!wrReload |=> $stable(reload_q))
    else $error("reload value changed without write");

  chk_ovf_sticky: assert property (st_q[ST_OVF] && !stClr[ST_OVF] |=> st_q[ST_OVF])
    else $error("overflow flag lost");

  chk_req_cause: assert property ($rose(req_q) |-> $past(ovf) || $past(early))
    else $error("reset request without cause");

  cov_overflow: cover property (ovf);
  cov_early: cover property (early);
  cov_good_service: cover property (svc && wdEn_q && !early);
  cov_irq: cover property (irq_q);
  cov_stop: cover property (disCmd && !enCmd);
endmodule // wwd_top
`default_nettype wire

// ---- tb/wwd_wake_partner.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Wake oscillator and reset controller
// ----------------------------------------
module wwd_wake_partner (
  // Watchdog side
  input  wire logic wdResetReq,
  output var  logic wakeClk,
  output var  int   reqCount
);
  // Free running 500 kHz source, phase unrelated to ref_clk
  initial begin
    wakeClk = 1'b0;
    #317;
    forever #1000 wakeClk = ~wakeClk;
  end

  // Counts reset requests seen by the reset controller
  initial reqCount = 0;
  always @(posedge wdResetReq) reqCount++;
endmodule // wwd_wake_partner
`default_nettype wire

// ---- tb/window_watchdog_timer_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module window_watchdog_timer_tb import wwd_pkg::*;;
  logic              ref_clk, arst_n, awValid, wValid, bReady, arValid, rReady;
  logic              awReady, wReady, bValid, arReady, rValid, wdResetReq, irq, wakeClk;
  logic [ADDR_W-1:0] awAddr, arAddr;
  logic [DATA_W-1:0] wData, rData;
  logic [1:0]        bResp, rResp;
  int                reqCount;
  int                fail_count = 0;
  int                compares = 0;

  wwd_top uut (.ref_clk(ref_clk), .arst_n(arst_n), .wakeClk(wakeClk),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .wdResetReq(wdResetReq), .irq(irq));

  wwd_wake_partner partner (.wdResetReq(wdResetReq), .wakeClk(wakeClk), .reqCount(reqCount));

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge ref_clk);
    awAddr  <= a;
    wData   <= d;
    awValid <= 1'b1;
    wValid  <= 1'b1;
    bReady  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awValid && awReady) awValid <= 1'b0;
      if (wValid && wReady) wValid <= 1'b0;
    end while (bValid !== 1'b1);
    bReady <= 1'b0;
    chk({30'h0000_0000, bResp}, {30'h0000_0000, er}, "write response");
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge ref_clk);
    arAddr  <= a;
    arValid <= 1'b1;
    rReady  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arValid && arReady) arValid <= 1'b0;
    end while (rValid !== 1'b1);
    rReady <= 1'b0;
    chk(rData, ed, "read data");
    chk({30'h0000_0000, rResp}, {30'h0000_0000, er}, "read response");
  endtask

  task automatic waitReq(input int lo, input int hi);
    int n;
    for (n = 0; n < hi && wdResetReq !== 1'b1; n++) @(posedge ref_clk);
    chk(32'(n >= lo && wdResetReq === 1'b1), 32'h0000_0001, "request timing");
  endtask

  task automatic flag(input logic f, input logic e, input string msg);
    chk({31'h0000_0000, f}, {31'h0000_0000, e}, msg);
  endtask

  task automatic doReset();
    @(posedge ref_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic end_sim();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    doReset();
    flag(wdResetReq, 1'b0, "request out of reset");
    rd(OFF_CTRL, 32'h0000_0003, RESP_OKAY);
    rd(OFF_RELOAD, 32'(65536 - (65000 + 255) / 256), RESP_OKAY);
    rd(OFF_WINDOW, 32'h0000_0000, RESP_OKAY);
    rd(OFF_MASK, 32'h0000_0000, RESP_OKAY);
    rd(OFF_STATUS, 32'h0000_0004, RESP_OKAY);
    rd(OFF_CMD, 32'h0000_0000, RESP_OKAY);
    rd(8'h1C, 32'h0000_0000, RESP_SLVERR);
    wr(8'h1C, 32'h0000_FFFF, RESP_SLVERR);
    rd(OFF_COUNT, 32'h0000_FF02, RESP_OKAY);
    repeat (13000) @(posedge ref_clk);
    rd(OFF_COUNT, 32'h0000_FF03, RESP_OKAY);
    $display("test regs done");
  endtask

  task automatic t_ovf();
    doReset();
    wr(OFF_CTRL, 32'h0000_0002, RESP_OKAY);
    wr(OFF_RELOAD, 32'h0000_1234, RESP_OKAY);
    wr(OFF_CMD, 32'h0000_0001, RESP_OKAY);
    rd(OFF_COUNT, 32'h0000_1234, RESP_OKAY);
    wr(OFF_COUNT, 32'h0000_0000, RESP_OKAY);
    repeat (1000) @(posedge ref_clk);
    rd(OFF_COUNT, 32'h0000_1237, RESP_OKAY);
    wr(OFF_RELOAD, 32'h0000_FFFE, RESP_OKAY);
    wr(OFF_CMD, 32'h0000_0001, RESP_OKAY);
    waitReq(2 * DIV_LO - 6, 2 * DIV_LO + 8);
    rd(OFF_STATUS, 32'h0000_000D, RESP_OKAY);
    flag(irq, 1'b0, "masked interrupt");
    wr(OFF_MASK, 32'h0000_0001, RESP_OKAY);
    repeat (2) @(posedge ref_clk);
    flag(irq, 1'b1, "overflow interrupt");
    wr(OFF_STATUS, 32'h0000_0001, RESP_OKAY);
    repeat (2) @(posedge ref_clk);
    flag(irq, 1'b0, "cleared interrupt");
    rd(OFF_STATUS, 32'h0000_000C, RESP_OKAY);
    flag(wdResetReq, 1'b1, "request held");
    $display("test overflow done");
  endtask

  task automatic t_early();
    doReset();
    wr(OFF_WINDOW, 32'h0000_FF02, RESP_OKAY);
    wr(OFF_CMD, 32'h0000_0001, RESP_OKAY);
    repeat (3) @(posedge ref_clk);
    flag(wdResetReq, 1'b0, "service on boundary");
    wr(OFF_WINDOW, 32'h0000_FF03, RESP_OKAY);
    wr(OFF_CMD, 32'h0000_0001, RESP_OKAY);
    waitReq(0, 3);
    rd(OFF_STATUS, 32'h0000_000E, RESP_OKAY);
    flag(irq, 1'b0, "masked interrupt");
    wr(OFF_MASK, 32'h0000_0002, RESP_OKAY);
    repeat (2) @(posedge ref_clk);
    flag(irq, 1'b1, "early interrupt");
    wr(OFF_STATUS, 32'h0000_0002, RESP_OKAY);
    repeat (2) @(posedge ref_clk);
    flag(irq, 1'b0, "cleared interrupt");
    rd(OFF_STATUS, 32'h0000_000C, RESP_OKAY);
    $display("test early done");
  endtask

  task automatic t_endis();
    doReset();
    wr(OFF_CTRL, 32'h0000_0002, RESP_OKAY);
    wr(OFF_RELOAD, 32'h0000_FFFE, RESP_OKAY);
    wr(OFF_CMD, 32'h0000_0003, RESP_OKAY);
    repeat (1500) @(posedge ref_clk);
    flag(wdResetReq, 1'b0, "request while stopped");
    rd(OFF_COUNT, 32'h0000_FFFE, RESP_OKAY);
    rd(OFF_STATUS, 32'h0000_0000, RESP_OKAY);
    wr(OFF_CMD, 32'h0000_0006, RESP_OKAY);
    rd(OFF_STATUS, 32'h0000_0004, RESP_OKAY);
    waitReq(DIV_LO - 16, 2 * DIV_LO + 8);
    $display("test enable done");
  endtask

  task automatic t_src();
    doReset();
    wr(OFF_CTRL, 32'h0000_0000, RESP_OKAY);
    wr(OFF_RELOAD, 32'h0000_FFFF, RESP_OKAY);
    wr(OFF_CMD, 32'h0000_0001, RESP_OKAY);
    waitReq(DIV_HI - 12, DIV_HI + 12);
    doReset();
    wr(OFF_RELOAD, 32'h0000_FFFF, RESP_OKAY);
    wr(OFF_CMD, 32'h0000_0001, RESP_OKAY);
    waitReq(DIV_LO * 50 - 60, DIV_LO * 50 + 70);
    $display("test sources done");
  endtask

  // ----------------------------------------
  // Clock, sequence and watchdog
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  initial begin
    arst_n  = 1'b0;
    awValid = 1'b0;
    wValid  = 1'b0;
    bReady  = 1'b0;
    arValid = 1'b0;
    rReady  = 1'b0;
    awAddr  = 8'h00;
    arAddr  = 8'h00;
    wData   = 32'h0000_0000;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_regs();
    t_ovf();
    t_early();
    t_endis();
    t_src();
    chk(32'(reqCount), 32'h0000_0005, "request count");
    end_sim();
  end

  initial begin
    #4_000_000;
    fail_count++;
    $display("BAD t=%0t run did not finish", $time);
    end_sim();
  end
endmodule // window_watchdog_timer_tb
`default_nettype wire
